// ===== hw/vga_host_pkg.sv
/*
 Constants shared by the serial-link host controller for the dual-channel
 variable gain amplifier: frame layout, device register map, field
 positions, reset values and timing.
 Assumes a 100 MHz system clock and a link clock generated by the host.
*/
package vga_host_pkg;
   // ------------------------------------------------------------
   // Frame layout
   // ------------------------------------------------------------
   localparam int          FRAME_BITS     = 32;
   localparam int          DATA_BITS      = 24;
   localparam int          ADDR_BITS      = 5;
   localparam int          CHIP_BITS      = 3;
   localparam logic [2:0]  CHIP_CODE      = 3'h6;
   // ------------------------------------------------------------
   // Device register map
   // ------------------------------------------------------------
   localparam logic [4:0]  DEV_PTR_ADDR   = 5'h00;
   localparam logic [4:0]  DEV_ENABLE_ADDR = 5'h01;
   localparam logic [4:0]  DEV_SETTINGS_ADDR = 5'h02;
   localparam logic [4:0]  DEV_GAIN_ADDR  = 5'h03;
   localparam logic [23:0] SOFT_CLEAR_ARM = 24'h00_0020;
   localparam logic [23:0] SOFT_CLEAR_FIRE = 24'h00_0000;
   localparam int          EN_I_BIT       = 0;
   localparam int          EN_Q_BIT       = 1;
   localparam int          SET_SRC_BIT    = 5;
   localparam int          SET_NODEC_BIT  = 6;
   localparam int          SET_NODEGL_BIT = 7;
   localparam logic [6:0]  GAIN_CODE_MAX  = 7'h50;
   // ------------------------------------------------------------
   // Host register map (word offsets of the local port)
   // ------------------------------------------------------------
   localparam logic [3:0]  H_CTRL         = 4'h0;
   localparam logic [3:0]  H_TXDATA       = 4'h1;
   localparam logic [3:0]  H_TXADDR       = 4'h2;
   localparam logic [3:0]  H_STATUS       = 4'h3;
   localparam logic [3:0]  H_RXDATA       = 4'h4;
   localparam logic [3:0]  H_RXTAIL       = 4'h5;
   localparam logic [3:0]  H_GAIN         = 4'h6;
   localparam logic [3:0]  H_DIV          = 4'h7;
   localparam int          CTRL_GO_BIT    = 0;
   localparam int          CTRL_READ_BIT  = 1;
   localparam int          CTRL_SOFT_BIT  = 2;
   localparam logic [15:0] DIV_RESET      = 16'h0002;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int          CLK_PERIOD_NS  = 10;
   localparam int          SEN_HIGH_NS    = 20;
   localparam int          SEN_HIGH_CYC   = (SEN_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          POR_US         = 250;
   localparam int          POR_CYC        = POR_US * 1000 / CLK_PERIOD_NS;
   typedef enum logic [5:0] {
      ST_IDLE = 6'b00_0001,
      ST_LEAD = 6'b00_0010,
      ST_LOW  = 6'b00_0100,
      ST_HIGH = 6'b00_1000,
      ST_GAP  = 6'b01_0000,
      ST_WAIT = 6'b10_0000
   } link_state_t;
endpackage : vga_host_pkg

// ===== hw/half_period_divider.sv
/*
 Enable pulse generator: one-cycle pulse every (div+1) system cycles.
 Assumes div is held steady while running; restarts when run is low.
*/
`timescale 1ns/1ps
module half_period_divider #(
   parameter int W = 16
) (
   input  wire logic         sys_clk,
   input  wire logic         rstn,
   input  wire logic         run,
   input  wire logic [W-1:0] div,
   output logic              tick
);
   logic [W-1:0] cnt_reg;
   wire          at_end = (cnt_reg >= div);

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_reg <= '0;
         tick    <= 1'b0;
      end else begin
         tick    <= run && at_end;
         cnt_reg <= (!run || at_end) ? '0 : cnt_reg + 1'b1;
      end
   end
endmodule : half_period_divider

// ===== hw/bit_sync.sv
/*
 Two-stage synchroniser for one level from outside the clock domain.
 Assumes the input is a plain level; no edge logic reads the first stage.
*/
`timescale 1ns/1ps
module bit_sync (
   input  wire logic sys_clk,
   input  wire logic rstn,
   input  wire logic d,
   output logic      q
);
   logic meta_reg;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         meta_reg <= 1'b0;
         q        <= 1'b0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule : bit_sync

// ===== hw/vga_link_host.sv
/*
 Host controller for the serial register port of a dual-channel variable
 gain amplifier. Software issues frames through a small local register
 port; the block drives frame enable, shift clock and serial data, and
 captures the device's serial output. Also drives the parallel gain pins.
 Assumes the device samples on rising shift-clock edges and shifts out on
 rising edges; the serial output is asynchronous and is synchronised here.
*/
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module vga_link_host
   import vga_host_pkg::*;
#(
   parameter int POR_WAIT = POR_CYC
) (
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   input  wire logic [3:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata,
   output logic             frame_enable_n,
   output logic             shift_clk,
   output logic             serial_in_line,
   input  wire logic        serial_out_line,
   output logic      [6:0]  gain_pins,
   output logic             busy
);
   // ------------------------------------------------------------
   // Local registers and state
   // ------------------------------------------------------------
   logic [23:0]  txdata_reg;
   logic [4:0]   txaddr_reg;
   logic [15:0]  div_reg;
   logic [6:0]   gain_reg;
   logic [31:0]  shift_reg;
   logic [31:0]  cap_reg;
   logic [5:0]   bit_cnt_reg;
   logic [15:0]  gap_cnt_reg;
   logic [$clog2(POR_WAIT+1)-1:0] por_cnt_reg;
   logic         por_done_reg;
   logic         read_pend_reg;
   logic         soft_pend_reg;
   logic         rx_valid_reg;
   logic         cur_read_reg;
   link_state_t  state_reg;
   logic         tick;
   logic         sdo_s;

   wire         in_frame   = (state_reg == ST_LOW) || (state_reg == ST_HIGH);
   wire         div_run    = (state_reg != ST_IDLE) && (state_reg != ST_WAIT);
   wire         wr_ctrl    = wr && (addr == H_CTRL);
   wire         go_req     = wr_ctrl && wdata[CTRL_GO_BIT];
   wire         soft_req   = wr_ctrl && wdata[CTRL_SOFT_BIT];
   wire         last_bit   = (bit_cnt_reg == 6'(FRAME_BITS - 1));
   wire  [31:0] frame_word = {txdata_reg, txaddr_reg, CHIP_CODE};
   wire  [31:0] ptr_word   = {19'h0_0000, txaddr_reg, DEV_PTR_ADDR, CHIP_CODE};
   wire  [31:0] keep_word  = {19'h0_0000, txaddr_reg, DEV_PTR_ADDR, CHIP_CODE};
   wire  [31:0] arm_word   = {SOFT_CLEAR_ARM, DEV_PTR_ADDR, CHIP_CODE};
   wire  [31:0] fire_word  = {SOFT_CLEAR_FIRE, DEV_PTR_ADDR, CHIP_CODE};
   wire  [31:0] status_w   = {27'h000_0000, por_done_reg, rx_valid_reg,
                              soft_pend_reg, read_pend_reg, busy};

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   half_period_divider #(.W(16)) u_div (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .run     (div_run),
      .div     (div_reg),
      .tick    (tick)
   );

   // Device output is asynchronous to our clock
   bit_sync u_sdo_sync (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .d       (serial_out_line),
      .q       (sdo_s)
   );

   // ------------------------------------------------------------
   // Power-up wait: no frame until device defaults have settled
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         por_cnt_reg  <= '0;
         por_done_reg <= 1'b0;
      end else if (!por_done_reg) begin
         por_cnt_reg  <= por_cnt_reg + 1'b1;
         por_done_reg <= (por_cnt_reg == ($bits(por_cnt_reg))'(POR_WAIT - 1));
      end
   end

   // ------------------------------------------------------------
   // Local register port
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         txdata_reg <= '0;
         txaddr_reg <= '0;
         div_reg    <= DIV_RESET;
         gain_reg   <= '0;
         gain_pins  <= '0;
      end else begin
         if (wr && addr == H_TXDATA) txdata_reg <= wdata[23:0];
         if (wr && addr == H_TXADDR) txaddr_reg <= wdata[4:0];
         if (wr && addr == H_DIV) div_reg <= (wdata[15:0] == 16'h0000) ? 16'h0001 : wdata[15:0];
         if (wr && addr == H_GAIN) begin
            // Clamp to the top decoded code
            gain_reg <= (wdata[6:0] > GAIN_CODE_MAX) ? GAIN_CODE_MAX : wdata[6:0];
         end
         gain_pins <= gain_reg;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= '0;
      end else if (rd) begin
         unique case (addr)
            H_CTRL:   rdata <= 32'h0000_0000;
            H_TXDATA: rdata <= {8'h00, txdata_reg};
            H_TXADDR: rdata <= {27'h000_0000, txaddr_reg};
            H_STATUS: rdata <= status_w;
            H_RXDATA: rdata <= {8'h00, cap_reg[31:8]};
            H_RXTAIL: rdata <= {24'h00_0000, cap_reg[7:0]};
            H_GAIN:   rdata <= {25'h000_0000, gain_reg};
            H_DIV:    rdata <= {16'h0000, div_reg};
            default:  rdata <= 32'h0000_0000;
         endcase
      end else begin
         rdata <= '0;
      end
   end

   // ------------------------------------------------------------
   // Frame engine
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg      <= ST_IDLE;
         frame_enable_n <= 1'b1;
         shift_clk      <= 1'b0;
         serial_in_line <= 1'b0;
         shift_reg      <= '0;
         cap_reg        <= '0;
         bit_cnt_reg    <= '0;
         gap_cnt_reg    <= '0;
         read_pend_reg  <= 1'b0;
         soft_pend_reg  <= 1'b0;
         rx_valid_reg   <= 1'b0;
         cur_read_reg   <= 1'b0;
         busy           <= 1'b0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (por_done_reg && (go_req || soft_req)) begin
                  busy          <= 1'b1;
                  rx_valid_reg  <= 1'b0;
                  // Soft clear wins over a read so its two frames stay back to back
                  read_pend_reg <= go_req && !soft_req && wdata[CTRL_READ_BIT];
                  soft_pend_reg <= soft_req;
                  cur_read_reg  <= 1'b0;
                  shift_reg     <= soft_req ? arm_word
                                 : (wdata[CTRL_READ_BIT] ? ptr_word : frame_word);
                  state_reg     <= ST_LEAD;
               end
            end
            ST_LEAD: begin
               // Enable low and MSB set a full period (two ticks) before first rise
               frame_enable_n <= 1'b0;
               serial_in_line <= shift_reg[31];
               bit_cnt_reg    <= '0;
               if (tick) state_reg <= ST_LOW;
            end
            ST_LOW: if (tick) begin
               shift_clk <= 1'b1;
               state_reg <= ST_HIGH;
            end
            ST_HIGH: if (tick) begin
               shift_clk <= 1'b0;
               // Sample device output at our falling edge
               if (cur_read_reg) cap_reg <= {cap_reg[30:0], sdo_s};
               if (last_bit) begin
                  state_reg      <= ST_GAP;
                  gap_cnt_reg    <= '0;
                  rx_valid_reg   <= cur_read_reg;
               end else begin
                  shift_reg      <= {shift_reg[30:0], 1'b0};
                  serial_in_line <= shift_reg[30];
                  bit_cnt_reg    <= bit_cnt_reg + 1'b1;
                  state_reg      <= ST_LOW;
               end
            end
            ST_GAP: begin
               // One cycle after the last fall, so the enable never moves with it
               frame_enable_n <= 1'b1;
               gap_cnt_reg    <= gap_cnt_reg + 1'b1;
               if (gap_cnt_reg >= 16'(SEN_HIGH_CYC) && tick) begin
                  if (read_pend_reg) begin
                     read_pend_reg <= 1'b0;
                     cur_read_reg  <= 1'b1;
                     shift_reg     <= keep_word;
                     state_reg     <= ST_LEAD;
                  end else if (soft_pend_reg) begin
                     soft_pend_reg <= 1'b0;
                     shift_reg     <= fire_word;
                     state_reg     <= ST_LEAD;
                  end else begin
                     state_reg <= ST_WAIT;
                  end
               end
            end
            ST_WAIT: begin
               busy         <= 1'b0;
               cur_read_reg <= 1'b0;
               state_reg    <= ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   logic [6:0] rise_cnt;
   logic       sck_d;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rise_cnt <= '0;
         sck_d    <= 1'b0;
      end else begin
         sck_d <= shift_clk;
         if (frame_enable_n) rise_cnt <= '0;
         else if (shift_clk && !sck_d) rise_cnt <= rise_cnt + 1'b1;
      end
   end

   chk_frame_len: assert property (@(posedge sys_clk) disable iff (!rstn)
      $rose(frame_enable_n) |-> rise_cnt == 7'd32)
      else $error("frame did not carry 32 clock rises");
   chk_sdi_on_fall: assert property (@(posedge sys_clk) disable iff (!rstn)
      $changed(serial_in_line) && !$rose(frame_enable_n) |-> !shift_clk)
      else $error("input line changed while shift clock high");
   chk_no_sck_rise_idle: assert property (@(posedge sys_clk) disable iff (!rstn)
      frame_enable_n |-> !$rose(shift_clk))
      else $error("shift clock rose outside a frame");
   chk_sen_rise_low: assert property (@(posedge sys_clk) disable iff (!rstn)
      $rose(frame_enable_n) |-> !shift_clk)
      else $error("enable rose with shift clock high");
   chk_first_bit: assert property (@(posedge sys_clk) disable iff (!rstn)
      $rose(shift_clk) && rise_cnt == 7'd0 |-> !frame_enable_n
         && serial_in_line == $past(shift_reg[31]))
      else $error("first rise without enable or data MSB");
   chk_chip_tail: assert property (@(posedge sys_clk) disable iff (!rstn)
      state_reg == ST_LEAD |-> shift_reg[2:0] == CHIP_CODE)
      else $error("frame lacks the fixed chip code");
   chk_read_ptr: assert property (@(posedge sys_clk) disable iff (!rstn)
      state_reg == ST_LEAD && read_pend_reg |-> shift_reg[7:3] == DEV_PTR_ADDR)
      else $error("pointer frame not aimed at register 0");
   chk_gain_range: assert property (@(posedge sys_clk) disable iff (!rstn)
      gain_pins <= GAIN_CODE_MAX)
      else $error("gain code above the top step");
   chk_por_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
      !por_done_reg |-> frame_enable_n)
      else $error("frame started before power-up wait");
   chk_soft_pair: assert property (@(posedge sys_clk) disable iff (!rstn)
      state_reg == ST_LEAD && !soft_pend_reg && $past(state_reg) == ST_GAP
         && !cur_read_reg |-> shift_reg == fire_word)
      else $error("second soft clear frame not 00h");
   chk_enable_held: assert property (@(posedge sys_clk) disable iff (!rstn)
      in_frame |-> !frame_enable_n)
      else $error("enable high inside a frame");
   chk_bit_count: assert property (@(posedge sys_clk) disable iff (!rstn)
      in_frame |-> bit_cnt_reg < 6'(FRAME_BITS))
      else $error("bit counter past the frame length");
   chk_busy_frame: assert property (@(posedge sys_clk) disable iff (!rstn)
      !frame_enable_n |-> busy)
      else $error("frame enable low while not busy");
   chk_idle_quiet: assert property (@(posedge sys_clk) disable iff (!rstn)
      state_reg == ST_IDLE |-> frame_enable_n && !shift_clk)
      else $error("link not quiet while idle");
   chk_sen_after_fall: assert property (@(posedge sys_clk) disable iff (!rstn)
      $rose(frame_enable_n) |-> !$fell(shift_clk))
      else $error("enable rose together with the last clock fall");
   chk_sck_low_gap: assert property (@(posedge sys_clk) disable iff (!rstn)
      state_reg == ST_GAP |-> !shift_clk)
      else $error("shift clock high between frames");
   chk_sdi_in_lead: assert property (@(posedge sys_clk) disable iff (!rstn)
      state_reg == ST_LOW && $past(state_reg) == ST_LEAD |-> serial_in_line == shift_reg[31])
      else $error("data MSB missing before first rise");
   chk_soft_first: assert property (@(posedge sys_clk) disable iff (!rstn)
      state_reg == ST_LEAD && soft_pend_reg |-> shift_reg == arm_word)
      else $error("first soft clear frame not 20h");
   chk_readback_ptr: assert property (@(posedge sys_clk) disable iff (!rstn)
      state_reg == ST_LEAD && cur_read_reg |-> shift_reg[7:3] == DEV_PTR_ADDR)
      else $error("readback frame not aimed at register 0");
   chk_rx_valid_read: assert property (@(posedge sys_clk) disable iff (!rstn)
      $rose(rx_valid_reg) |-> $past(cur_read_reg))
      else $error("capture flagged valid without a readback frame");
   chk_gain_follow: assert property (@(posedge sys_clk) disable iff (!rstn)
      gain_pins == $past(gain_reg))
      else $error("gain pins do not follow the gain register");
endmodule : vga_link_host

// ===== bench/vga_dev_model.sv
/*
 Pin-level model of the amplifier's serial register port.
 Assumes the host under test makes the shift clock; no pin delays.
*/
`timescale 1ns/1ps
module vga_dev_model
   import vga_host_pkg::*;
(
   input  wire logic   rstn,
   input  wire logic   frame_enable_n,
   input  wire logic   shift_clk,
   input  wire logic   serial_in_line,
   output logic        serial_out_line,
   output logic [23:0] ptr_reg,
   output logic [23:0] enable_reg,
   output logic [23:0] settings_reg,
   output logic [23:0] gain_reg,
   output logic [4:0]  last_addr,
   output int          commit_cnt,
   output int          err_cnt
);
   logic [31:0] shift_word;
   logic [31:0] out_word;
   logic        soft_armed;
   logic        rd_armed;
   logic        rd_active;
   logic        in_frame;
   int          nbit;
   realtime     t_sdi;
   realtime     t_fall;

   task automatic load_defaults;
      ptr_reg = 24'h00_0000;
      enable_reg = 24'h00_0000;
      settings_reg = 24'h00_0015;
      gain_reg = 24'h00_0000;
      soft_armed = 1'b0;
      rd_armed = 1'b0;
   endtask : load_defaults

   function automatic logic [23:0] reg_value(input logic [4:0] a);
      case (a)
         DEV_PTR_ADDR:      return ptr_reg;
         DEV_ENABLE_ADDR:   return enable_reg;
         DEV_SETTINGS_ADDR: return settings_reg;
         DEV_GAIN_ADDR:     return gain_reg;
         default:           return 24'h00_0000;
      endcase
   endfunction : reg_value

   task automatic commit(input logic [4:0] a, input logic [23:0] d);
      commit_cnt++;
      last_addr = a;
      case (a)
         DEV_PTR_ADDR: begin
            ptr_reg = d;
            if (soft_armed && d == SOFT_CLEAR_FIRE) load_defaults();
            else soft_armed = (d == SOFT_CLEAR_ARM);
            rd_armed = 1'b1;
         end
         DEV_ENABLE_ADDR:   enable_reg = d;
         DEV_SETTINGS_ADDR: settings_reg = d;
         DEV_GAIN_ADDR:     gain_reg = d;
         default:           soft_armed = 1'b0;
      endcase
   endtask : commit

   // ----------------------------------------
   // Link side
   // ----------------------------------------
   initial begin
      load_defaults();
      serial_out_line = 1'b1;
      commit_cnt = 0;
      err_cnt = 0;
      nbit = 0;
      rd_active = 1'b0;
      in_frame = 1'b0;
      t_sdi = 0.0;
      t_fall = 0.0;
   end
   always @(negedge shift_clk) t_fall = $realtime;
   always @(negedge rstn) load_defaults();
   always @(serial_in_line) t_sdi = $realtime;
   always @(negedge frame_enable_n) begin
      in_frame = 1'b1;
      nbit = 0;
      shift_word = 32'h0000_0000;
      rd_active = rd_armed;
      rd_armed = 1'b0;
      out_word = {reg_value(ptr_reg[4:0]), ptr_reg[4:0], CHIP_CODE};
   end
   always @(posedge shift_clk) begin
      if (!frame_enable_n) begin
         if ($realtime - t_sdi < 8.0) err_cnt++;
         shift_word = {shift_word[30:0], serial_in_line};
         if (rd_active && nbit < FRAME_BITS) serial_out_line = out_word[31 - nbit];
         nbit++;
      end
   end
   always @(posedge frame_enable_n) begin
      if (in_frame) begin
         // Released line shows the inverse so a stale bit is never read as good
         if (rd_active) serial_out_line = ~serial_out_line;
         rd_active = 1'b0;
         in_frame = 1'b0;
         if (nbit != FRAME_BITS) err_cnt++;
         if (shift_clk || $realtime - t_fall < 8.0) err_cnt++;
         if (nbit == FRAME_BITS && shift_word[2:0] == CHIP_CODE)
            commit(shift_word[7:3], shift_word[31:8]);
      end
   end
endmodule : vga_dev_model

// ===== bench/testbench.sv
/*
 Self-checking bench for the serial-link host controller.
 Assumes the device model sits on the link; the local port is driven here.
*/
`timescale 1ns/1ps
module testbench;
   import vga_host_pkg::*;
   logic        sys_clk;
   logic        rstn;
   logic [3:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic        frame_enable_n;
   logic        shift_clk;
   logic        serial_in_line;
   logic        serial_out_line;
   logic [6:0]  gain_pins;
   logic        busy;
   logic [23:0] ptr_r;
   logic [23:0] en_r;
   logic [23:0] set_r;
   logic [23:0] gain_r;
   logic [4:0]  last_addr;
   logic [31:0] got;
   int          commit_cnt;
   int          err_cnt;
   int          n_fail;
   int          num_checks;

   vga_link_host #(.POR_WAIT(20)) u_dut (.sys_clk(sys_clk), .rstn(rstn), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .frame_enable_n(frame_enable_n),
      .shift_clk(shift_clk), .serial_in_line(serial_in_line),
      .serial_out_line(serial_out_line), .gain_pins(gain_pins), .busy(busy));
   vga_dev_model u_dev (.rstn(rstn), .frame_enable_n(frame_enable_n), .shift_clk(shift_clk),
      .serial_in_line(serial_in_line), .serial_out_line(serial_out_line), .ptr_reg(ptr_r),
      .enable_reg(en_r), .settings_reg(set_r), .gain_reg(gain_r), .last_addr(last_addr),
      .commit_cnt(commit_cnt), .err_cnt(err_cnt));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic print_verdict;
      if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict

   task automatic check(input logic [31:0] g, input logic [31:0] e, input string what);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, g, e);
      end
   endtask : check

   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [3:0] a);
      @(posedge sys_clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1 got = rdata;
   endtask : reg_rd

   // Bounded: a link that never goes idle ends the run
   task automatic wait_idle;
      int i;
      repeat (3) @(posedge sys_clk);
      #1;
      for (i = 0; i < 4000 && busy !== 1'b0; i++) begin
         @(posedge sys_clk);
         #1;
      end
      if (busy !== 1'b0) begin
         n_fail++;
         $display("wrong value at %0t: link stays busy", $time);
         print_verdict();
      end
   endtask : wait_idle

   task automatic send(input logic [4:0] a, input logic [23:0] d, input logic [31:0] ctl);
      reg_wr(H_TXDATA, {8'h00, d});
      reg_wr(H_TXADDR, 32'(a));
      reg_wr(H_CTRL, ctl);
      wait_idle();
   endtask : send

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_power_up;
      int i;
      reg_rd(H_STATUS);
      check(got & 32'h0000_0010, 32'h0000_0000, "early ready flag");
      reg_wr(H_CTRL, 32'h0000_0001);
      reg_rd(H_DIV);
      check(got, 32'h0000_0002, "divider reset value");
      reg_rd(4'hA);
      check(got, 32'h0000_0000, "unmapped read");
      for (i = 0; i < 100 && got[4] !== 1'b1; i++) reg_rd(H_STATUS);
      check(32'(got[4]), 32'h0000_0001, "ready flag");
      check(32'(commit_cnt), 32'h0000_0000, "frame before ready");
   endtask : t_power_up

   task automatic t_write;
      reg_wr(H_DIV, 32'h0000_0003);
      send(DEV_ENABLE_ADDR, 24'h00_0003, 32'h0000_0001);
      check(32'(en_r), 32'h0000_0003, "enable reg");
      check(32'(last_addr), 32'(DEV_ENABLE_ADDR), "frame addr");
      reg_wr(H_TXDATA, 32'h0080_00F5);
      reg_wr(H_TXADDR, 32'(DEV_SETTINGS_ADDR));
      reg_wr(H_CTRL, 32'h0000_0001);
      reg_wr(H_CTRL, 32'h0000_0001);
      wait_idle();
      check(32'(commit_cnt), 32'h0000_0002, "go while busy");
      check(32'(set_r), 32'h0080_00F5, "settings reg");
      send(DEV_GAIN_ADDR, 24'h00_0150, 32'h0000_0001);
      check(32'(gain_r), 32'h0000_0150, "gain reg");
   endtask : t_write

   task automatic t_read(input logic [4:0] a, input logic [23:0] e);
      int c0;
      logic [23:0] s0;
      c0 = commit_cnt;
      s0 = set_r;
      send(a, 24'h00_0000, 32'h0000_0003);
      check(32'(commit_cnt - c0), 32'h0000_0002, "read frames");
      check(32'(ptr_r), 32'(a), "pointer kept");
      check(32'(set_r), 32'(s0), "state kept");
      reg_rd(H_STATUS);
      check(32'(got[3]), 32'h0000_0001, "capture valid");
      reg_rd(H_RXDATA);
      check(got, {8'h00, e}, "read data");
      reg_rd(H_RXTAIL);
      check(got, {24'h00_0000, a, CHIP_CODE}, "read tail");
   endtask : t_read

   task automatic t_soft;
      reg_wr(H_CTRL, 32'h0000_0004);
      wait_idle();
      check(32'(en_r), 32'h0000_0000, "enable cleared");
      check(32'(set_r), 32'h0000_0015, "settings default");
      check(32'(gain_r), 32'h0000_0000, "gain default");
      t_read(DEV_SETTINGS_ADDR, 24'h00_0015);
   endtask : t_soft

   task automatic gain_case(input logic [31:0] d, input logic [6:0] e);
      reg_wr(H_GAIN, d);
      repeat (2) @(posedge sys_clk);
      #1 check(32'(gain_pins), 32'(e), "gain pins");
   endtask : gain_case

   initial begin
      rstn = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 32'h0000_0000;
      got = 32'h0000_0000;
      n_fail = 0;
      num_checks = 0;
      repeat (8) @(posedge sys_clk);
      rstn <= 1'b1;
      t_power_up();
      t_write();
      t_read(DEV_SETTINGS_ADDR, 24'h80_00F5);
      t_read(DEV_ENABLE_ADDR, 24'h00_0003);
      t_soft();
      gain_case(32'h0000_0030, 7'h30);
      gain_case(32'h0000_0050, 7'h50);
      gain_case(32'h0000_007F, 7'h50);
      gain_case(32'h0000_0000, 7'h00);
      check(32'(err_cnt), 32'h0000_0000, "link timing faults");
      print_verdict();
   end
endmodule : testbench
